// ===== verilog/mwt_pkg.sv
// Purpose: shared constants for the wait table setup decoder
// Assumes: 16-bit instruction words, one core clock
// Notes: field positions are bit indices inside the instruction word
package mwt_pkg;

  // ==========================================================
  // widths and table size
  localparam int INSTR_W = 16;
  localparam int DATA_W = 16;
  localparam int REG_IDX_W = 5;
  localparam int COND_W = 6;
  localparam int ROW_SEL_W = 3;
  localparam int NUM_ROWS = 5;
  localparam int NUM_CODES = 64;

  // ==========================================================
  // register copy word: 101 src[12:8] dst[7:3] 000
  localparam logic [2:0] CP_OPCODE = 3'h5;
  localparam int CP_OPC_LSB = 13;
  localparam int CP_SRC_LSB = 8;
  localparam int CP_DST_LSB = 3;
  localparam logic [2:0] CP_TAIL = 3'h0;

  // ==========================================================
  // far entry word: 000100 jreg[9] row[8:6] cond[5:0]
  localparam logic [5:0] CWEF_OPCODE = 6'h04;
  localparam int CWEF_OPC_LSB = 10;
  localparam int CWEF_JREG_BIT = 9;
  localparam int CWEF_ROW_LSB = 6;
  localparam int CWEF_COND_LSB = 0;
  localparam logic [2:0] ROW_SEL_MAX = 3'h4;

  // ==========================================================
  // reset values
  localparam logic [5:0] ROW_COND_RST = 6'h00;
  localparam logic ROW_JREG_RST = 1'b0;
  localparam logic [15:0] DATA_RST = 16'h0000;
  localparam logic [4:0] REG_IDX_RST = 5'h00;
  localparam logic [2:0] ROW_RST = 3'h0;

  // ==========================================================
  // sequencer states
  typedef enum logic [1:0] {
    MWT_IDLE = 2'b00,
    MWT_COPY_RD = 2'b01
  } mwt_state_type;

endpackage

// ===== verilog/mwt_cond_eval.sv
// Purpose: turns the condition sources into one truth bit per code
// Assumes: all sources are already on the core clock
// Notes: purely combinational; the table indexes the result
module mwt_cond_eval (
  // flags and counters
  input wire logic [15:0] flags_in,
  input wire logic [3:0] term_count_in,
  input wire logic start_in,
  // shortcut feedbacks, index 0 is shortcut 1
  input wire logic [2:0] shortcut_vds_in,
  input wire logic [2:0] shortcut_src_in,
  // arithmetic unit and boost
  input wire logic alu_done_in,
  input wire logic boost_in,
  // current feedbacks: 1, 2, 3, 4l, 4h, 4n, then own
  input wire logic [5:0] current_fb_in,
  input wire logic own_current_fb_in,
  // truth of every condition code
  output logic [63:0] cond_true_out
);

  // ==========================================================
  // code map: bit n of the vector is the truth of code n
  always_comb begin
    cond_true_out[15:0] = ~flags_in;
    cond_true_out[31:16] = flags_in;
    cond_true_out[35:32] = term_count_in;
    cond_true_out[36] = ~start_in;
    cond_true_out[37] = start_in;
    cond_true_out[40:38] = ~shortcut_vds_in;
    cond_true_out[43:41] = ~shortcut_src_in;
    cond_true_out[46:44] = shortcut_vds_in;
    cond_true_out[47] = alu_done_in;
    cond_true_out[48] = boost_in;
    cond_true_out[49] = ~boost_in;
    cond_true_out[55:50] = current_fb_in;
    cond_true_out[61:56] = ~current_fb_in;
    cond_true_out[62] = own_current_fb_in;
    cond_true_out[63] = ~own_current_fb_in;
  end

endmodule

// ===== verilog/mwt_decoder.sv
// Purpose: register copy and far wait entry decoder with wait table
// Assumes: register file reads combinationally from a registered index
// Notes: the wait instruction itself lives in the sequencer
module mwt_decoder (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // instruction from fetch
  input wire logic instr_valid_in,
  input wire logic [15:0] instr_in,
  output logic instr_ready_out,
  // register file, read side and write side
  output logic [4:0] rf_rd_idx_out,
  input wire logic [15:0] rf_rd_data_in,
  output logic rf_wr_en_out,
  output logic [4:0] rf_wr_idx_out,
  output logic [15:0] rf_wr_data_out,
  // jump registers holding absolute addresses
  input wire logic [15:0] jump_reg0_in,
  input wire logic [15:0] jump_reg1_in,
  // wait request from the sequencer
  input wire logic wait_active_in,
  input wire logic [4:0] wait_row_en_in,
  output logic wait_hit_out,
  output logic [2:0] wait_row_out,
  output logic [15:0] wait_dest_out,
  // condition sources
  input wire logic [15:0] flags_in,
  input wire logic [3:0] term_count_in,
  input wire logic start_in,
  input wire logic [2:0] shortcut_vds_in,
  input wire logic [2:0] shortcut_src_in,
  input wire logic alu_done_in,
  input wire logic boost_in,
  input wire logic [5:0] current_fb_in,
  input wire logic own_current_fb_in
);

  // ==========================================================
  // state record
  typedef struct packed {
    mwt_pkg::mwt_state_type st;
    logic ready;
    logic [4:0] rd_idx;
    logic [4:0] dst_idx;
    logic wr_en;
    logic [4:0] wr_idx;
    logic [15:0] wr_data;
    logic [4:0] row_valid;
    logic [4:0][5:0] row_cond;
    logic [4:0] row_jreg;
    logic hit;
    logic [2:0] hit_row;
    logic [15:0] dest;
  } mwt_regs_type;

  mwt_regs_type r;
  mwt_regs_type next_r;
  logic [63:0] cond_true;
  logic [4:0] row_match;
  logic take;
  logic is_copy;
  logic is_far;
  logic [2:0] sel_row;

  // row select check, also used by the checks below
  function automatic logic row_sel_ok(input logic [2:0] sel);
    row_sel_ok = (sel <= mwt_pkg::ROW_SEL_MAX);
  endfunction

  // ==========================================================
  // condition truth vector
  mwt_cond_eval u_cond (
    .flags_in(flags_in),
    .term_count_in(term_count_in),
    .start_in(start_in),
    .shortcut_vds_in(shortcut_vds_in),
    .shortcut_src_in(shortcut_src_in),
    .alu_done_in(alu_done_in),
    .boost_in(boost_in),
    .current_fb_in(current_fb_in),
    .own_current_fb_in(own_current_fb_in),
    .cond_true_out(cond_true)
  );

  // ==========================================================
  // per-row match, all rows side by side
  for (genvar g = 0; g < mwt_pkg::NUM_ROWS; g++) begin : g_row
    assign row_match[g] = wait_row_en_in[g] & r.row_valid[g] &
                          cond_true[r.row_cond[g]];
  end

  // instruction decode
  assign take = instr_valid_in & r.ready;
  assign is_copy = instr_in[15:mwt_pkg::CP_OPC_LSB] == mwt_pkg::CP_OPCODE
                   && instr_in[2:0] == mwt_pkg::CP_TAIL;
  assign is_far = instr_in[15:mwt_pkg::CWEF_OPC_LSB] ==
                  mwt_pkg::CWEF_OPCODE;
  assign sel_row = instr_in[mwt_pkg::CWEF_ROW_LSB +: 3];

  // ==========================================================
  // next-state logic
  always_comb begin
    next_r = r;
    next_r.wr_en = 1'b0;
    next_r.hit = 1'b0;
    unique case (r.st)
      mwt_pkg::MWT_IDLE: begin
        if (take && is_copy) begin
          // 5-bit operands span the whole core register subset
          next_r.rd_idx = instr_in[mwt_pkg::CP_SRC_LSB +: 5];
          next_r.dst_idx = instr_in[mwt_pkg::CP_DST_LSB +: 5];
          next_r.st = mwt_pkg::MWT_COPY_RD;
          next_r.ready = 1'b0;
        end else if (take && is_far && row_sel_ok(sel_row)) begin
          next_r.row_valid[sel_row] = 1'b1;
          next_r.row_cond[sel_row] =
            instr_in[mwt_pkg::CWEF_COND_LSB +: 6];
          // one bit: only the jump registers can be named
          next_r.row_jreg[sel_row] =
            instr_in[mwt_pkg::CWEF_JREG_BIT];
        end
      end
      mwt_pkg::MWT_COPY_RD: begin
        // read data is valid while the index is held
        next_r.wr_en = 1'b1;
        next_r.wr_idx = r.dst_idx;
        next_r.wr_data = rf_rd_data_in;
        next_r.st = mwt_pkg::MWT_IDLE;
        next_r.ready = 1'b1;
      end
      default: begin
        next_r.st = mwt_pkg::MWT_IDLE;
        next_r.ready = 1'b1;
      end
    endcase
    // lowest satisfied row decides; later rows are masked
    if (wait_active_in) begin
      for (int i = mwt_pkg::NUM_ROWS - 1; i >= 0; i--) begin
        if (row_match[i]) begin
          next_r.hit = 1'b1;
          next_r.hit_row = 3'(i);
          next_r.dest = r.row_jreg[i] ? jump_reg1_in
                                      : jump_reg0_in;
        end
      end
    end
  end

  // ==========================================================
  // registers; table clears only at reset
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      r.st <= mwt_pkg::MWT_IDLE;
      r.ready <= 1'b1;
      r.rd_idx <= mwt_pkg::REG_IDX_RST;
      r.dst_idx <= mwt_pkg::REG_IDX_RST;
      r.wr_en <= 1'b0;
      r.wr_idx <= mwt_pkg::REG_IDX_RST;
      r.wr_data <= mwt_pkg::DATA_RST;
      r.row_valid <= 5'h00;
      r.row_cond <= {5{mwt_pkg::ROW_COND_RST}};
      r.row_jreg <= {5{mwt_pkg::ROW_JREG_RST}};
      r.hit <= 1'b0;
      r.hit_row <= mwt_pkg::ROW_RST;
      r.dest <= mwt_pkg::DATA_RST;
    end else begin
      r <= next_r;
    end
  end

  // outputs straight from flops
  assign instr_ready_out = r.ready;
  assign rf_rd_idx_out = r.rd_idx;
  assign rf_wr_en_out = r.wr_en;
  assign rf_wr_idx_out = r.wr_idx;
  assign rf_wr_data_out = r.wr_data;
  assign wait_hit_out = r.hit;
  assign wait_row_out = r.hit_row;
  assign wait_dest_out = r.dest;

  // ==========================================================
  // checks
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);

  a_copy_write: assert property (
    take && is_copy && r.st == mwt_pkg::MWT_IDLE |=>
    ##1 rf_wr_en_out && rf_wr_idx_out == $past(instr_in[7:3], 2)
  ) else $error("copy did not write destination");

  a_copy_data: assert property (
    r.st == mwt_pkg::MWT_COPY_RD |=>
    rf_wr_data_out == $past(rf_rd_data_in)
  ) else $error("copy data differs from source");

  a_copy_src: assert property (
    take && is_copy && r.st == mwt_pkg::MWT_IDLE |=>
    rf_rd_idx_out == $past(instr_in[12:8]) && !instr_ready_out
  ) else $error("copy source index wrong");

  a_entry_store: assert property (
    take && is_far && !is_copy && row_sel_ok(sel_row) |=>
    r.row_valid[$past(sel_row)] &&
    r.row_cond[$past(sel_row)] == $past(instr_in[5:0]) &&
    r.row_jreg[$past(sel_row)] == $past(instr_in[9])
  ) else $error("far entry not stored");

  a_bad_row_keep: assert property (
    take && is_far && !row_sel_ok(sel_row) |=> $stable(r.row_cond) &&
    $stable(r.row_valid) && $stable(r.row_jreg)
  ) else $error("table changed on bad row");

  a_table_hold: assert property (
    !(take && is_far) |=> $stable(r.row_cond) && $stable(r.row_jreg)
  ) else $error("table changed without entry");

  a_hit_dest: assert property (
    wait_active_in && row_match[0] |=> wait_hit_out &&
    wait_row_out == 3'h0 && wait_dest_out ==
    ($past(r.row_jreg[0]) ? $past(jump_reg1_in) : $past(jump_reg0_in))
  ) else $error("row one hit gave wrong target");

  a_hit_lowest: assert property (
    wait_active_in && row_match[2] && !row_match[1] && !row_match[0]
    |=> wait_hit_out && wait_row_out == 3'h2
  ) else $error("lowest row did not win");

  a_no_hit: assert property (
    !wait_active_in || row_match == 5'h00 |=> !wait_hit_out
  ) else $error("hit with no matching row");

endmodule

// ===== testbench/mwt_reg_file_model.sv
// Purpose: core register file behind the copy path
// Assumes: combinational read of the decoder's registered index
// Notes: seeded per index so every register starts out with a distinct value
module mwt_reg_file_model (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // read and write sides
  input wire logic [4:0] rd_idx_in,
  output logic [15:0] rd_data_out,
  input wire logic wr_en_in,
  input wire logic [4:0] wr_idx_in,
  input wire logic [15:0] wr_data_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] regs [32];
  // ==========================================================
  // storage
  // read follows the index at once, as the decoder assumes
  assign rd_data_out = regs[rd_idx_in];
  // seed on reset, then take the decoder's one-cycle write strobe
  always_ff @(posedge clk_in) begin
    for (int i = 0; i < 32; i++) begin
      if (!rst_n_in) begin
        regs[i] <= 16'h5a00 ^ 16'(i * 16'h0111);
      end else if (wr_en_in && wr_idx_in == 5'(i)) begin
        regs[i] <= wr_data_in;
      end
    end
  end
endmodule

// ===== testbench/microcore_wait_table_setup_test.sv
// Purpose: self-checking bench for the copy and far entry decoder
// Assumes: inputs change 1 ns after the rising edge
// Notes: sources are random from a fixed lfsr seed
module microcore_wait_table_setup_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst_n, valid, ready, wr_en, act, hit, start, alu, boost, own, j;
  logic [15:0] instr, rd_data, wr_data, jr0, jr1, dest, flags;
  logic [4:0] rd_idx, wr_idx, en;
  logic [2:0] row, vds, src;
  logic [3:0] tc;
  logic [5:0] cur;
  logic [31:0] rnd = 32'h686a;
  logic [15:0] shadow [32];
  int fails = 0;
  int tests_run = 0;
  // ==========================================================
  // design and far side
  mwt_decoder dut_u (.core_clk_in(clk), .rst_n_in(rst_n),
    .instr_valid_in(valid), .instr_in(instr), .instr_ready_out(ready),
    .rf_rd_idx_out(rd_idx), .rf_rd_data_in(rd_data),
    .rf_wr_en_out(wr_en), .rf_wr_idx_out(wr_idx),
    .rf_wr_data_out(wr_data), .jump_reg0_in(jr0), .jump_reg1_in(jr1),
    .wait_active_in(act), .wait_row_en_in(en), .wait_hit_out(hit),
    .wait_row_out(row), .wait_dest_out(dest), .flags_in(flags),
    .term_count_in(tc), .start_in(start), .shortcut_vds_in(vds),
    .shortcut_src_in(src), .alu_done_in(alu), .boost_in(boost),
    .current_fb_in(cur), .own_current_fb_in(own));
  mwt_reg_file_model rf_u (.clk_in(clk), .rst_n_in(rst_n),
    .rd_idx_in(rd_idx), .rd_data_out(rd_data), .wr_en_in(wr_en),
    .wr_idx_in(wr_idx), .wr_data_in(wr_data));
  // ==========================================================
  // helpers
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // whole word per draw, one bit per step alone is too correlated
  function automatic logic [31:0] roll();
    repeat (32) rnd = {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]};
    return rnd;
  endfunction
  function automatic logic exp_cond(input logic [5:0] c);
    int i;
    i = int'(c);
    if (i < 16) return ~flags[i];
    if (i < 32) return flags[i - 16];
    if (i < 36) return tc[i - 32];
    if (i < 38) return start ^ (i == 36);
    if (i < 41) return ~vds[i - 38];
    if (i < 44) return ~src[i - 41];
    if (i < 47) return vds[i - 44];
    if (i == 47) return alu;
    if (i < 50) return boost ^ (i == 49);
    if (i < 56) return cur[i - 50];
    if (i < 62) return ~cur[i - 56];
    return own ^ (i == 63);
  endfunction
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] e, g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic do_reset();
    rst_n = 1'b0;
    repeat (8) tick();
    rst_n = 1'b1;
    for (int i = 0; i < 32; i++) shadow[i] = 16'h5a00 ^ 16'(i * 16'h0111);
  endtask
  // bounded wait; a copy blocks the next word for one cycle
  task automatic wait_ready();
    int n;
    n = 0;
    while (ready !== 1'b1 && n < 20) begin
      tick();
      n++;
    end
    if (ready !== 1'b1) begin
      check("ready wait", 16'h1, 16'h0);
      tally_and_finish();
    end
  endtask
  // leaves valid high so far entries can run back to back
  task automatic far(input logic [2:0] r, input logic [5:0] c, logic jb);
    wait_ready();
    instr = {6'h04, jb, r, c};
    valid = 1'b1;
    tick();
  endtask
  task automatic copy(input logic [4:0] s, d);
    wait_ready();
    instr = {3'h5, s, d, 3'h0};
    valid = 1'b1;
    tick();
    valid = 1'b0;
    check("copy ready", 16'h0, {15'h0, ready});
    check("copy rd idx", {11'h0, s}, {11'h0, rd_idx});
    tick();
    check("copy strobe", 16'h1, {15'h0, wr_en});
    check("copy wr idx", {11'h0, d}, {11'h0, wr_idx});
    check("copy data", shadow[s], wr_data);
    shadow[d] = shadow[s];
    tick();
    check("copy strobe end", 16'h0, {15'h0, wr_en});
  endtask
  task automatic eval(input logic [4:0] m, input logic eh,
                      input logic [2:0] er, input logic [15:0] ed);
    valid = 1'b0;
    act = 1'b1;
    en = m;
    tick();
    act = 1'b0;
    check("wait hit", {15'h0, eh}, {15'h0, hit});
    if (eh) begin
      check("wait row", {13'h0, er}, {13'h0, row});
      check("wait dest", ed, dest);
    end
  endtask
  // ==========================================================
  // main sequence
  initial begin
    {valid, act, start, alu, boost, own, j} = '0;
    {instr, jr0, jr1, flags, en, vds, src, tc, cur} = '0;
    do_reset();
    eval(5'h1f, 1'b0, 3'h0, 16'h0);
    $display("test empty table done");
    // every code twice, rows in turn, sources redrawn each time
    for (int k = 0; k < 128; k++) begin
      rnd = roll();
      {flags, tc, start, vds, src, alu, boost, own} = rnd[29:0];
      rnd = roll();
      jr0 = rnd[15:0];
      jr1 = rnd[31:16];
      cur = rnd[21:16] ^ rnd[5:0];
      j = rnd[7];
      far(3'(k % 5), 6'(k), j);
      eval(5'h1 << (k % 5), exp_cond(6'(k)), 3'(k % 5),
           j ? jr1 : jr0);
    end
    $display("test condition codes done");
    flags = 16'h0001;
    for (int i = 0; i < 5; i++) far(3'(i), 6'h10, i[0]);
    eval(5'h1f, 1'b1, 3'h0, jr0);
    eval(5'h1c, 1'b1, 3'h2, jr0);
    eval(5'h0a, 1'b1, 3'h1, jr1);
    $display("test priority done");
    far(3'h0, 6'h00, 1'b0);
    for (int i = 5; i < 8; i++) far(3'(i), 6'h10, 1'b1);
    eval(5'h01, 1'b0, 3'h0, 16'h0);
    eval(5'h1e, 1'b1, 3'h1, jr1);
    $display("test ignored rows done");
    for (int k = 0; k < 12; k++) begin
      rnd = roll();
      copy(rnd[4:0], (k == 3) ? rnd[4:0] : rnd[9:5]);
    end
    copy(5'h1f, 5'h00);
    copy(5'h00, 5'h11);
    // copy opcode with a nonzero tail must not start a copy
    instr = {3'h5, 5'h01, 5'h02, 3'h1};
    valid = 1'b1;
    tick();
    valid = 1'b0;
    check("bad tail ready", 16'h1, {15'h0, ready});
    tick();
    check("bad tail strobe", 16'h0, {15'h0, wr_en});
    eval(5'h1e, 1'b1, 3'h1, jr1);
    $display("test copies done");
    do_reset();
    check("reset ready", 16'h1, {15'h0, ready});
    check("reset dest", 16'h0, dest);
    eval(5'h1f, 1'b0, 3'h0, 16'h0);
    $display("test second reset done");
    tally_and_finish();
  end
endmodule
